// [ecdh_keygen_command_engine.sv]
// Command engine for the shared-secret and private-key generation commands.
`timescale 1ns/1ps
module ecdh_keygen_command_engine
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire ecdh_keygen_pkg::cmd_t cmd,
   output logic cmd_ready,
   input wire logic data_valid,
   input wire logic [7:0] data_byte,
   output logic data_ready,
   input wire logic [15:0] slot_is_ecc_priv,
   input wire logic [15:0] slot_is_ecc_pub,
   input wire logic [15:0] slot_ecdh_allowed,
   input wire logic [15:0] slot_locked,
   input wire logic secret_protect_option,
   input wire logic [255:0] io_protect_key,
   input wire logic [7:0] entropy_byte,
   output logic ecc_start,
   output ecdh_keygen_pkg::ecc_ctrl_t ecc_ctrl,
   output logic ecc_in_valid,
   output logic [7:0] ecc_in_byte,
   input wire logic ecc_done,
   input wire logic ecc_fail,
   input wire logic ecc_out_valid,
   input wire logic [7:0] ecc_out_byte,
   output logic rsp_valid,
   output logic [7:0] rsp_byte,
   output logic rsp_last,
   output logic asym_class,
   output logic scratch_key_valid_flag,
   output logic busy
);

   ecdh_keygen_pkg::state_t state_reg;
   ecdh_keygen_pkg::ecc_ctrl_t ctrl_next;
   logic enc_reg;
   logic enc_next;
   logic [7:0] err_reg;
   logic [7:0] err_next;
   logic [7:0] reply_reg;
   logic [5:0] cnt_reg;
   logic [5:0] out_last_reg;
   logic is_ecdh;
   logic is_gen;
   logic take;
   logic [3:0] slot;
   logic hi_zero;
   logic [7:0] mask_byte;
   logic [7:0] nonce_byte;

   assign take = cmd_valid && cmd_ready;
   assign slot = cmd.key_id[3:0];
   assign hi_zero = (cmd.key_id[15:4] == 12'h000);
   assign is_ecdh = (cmd.opcode == ecdh_keygen_pkg::OP_ECDH);
   assign is_gen = (cmd.opcode == ecdh_keygen_pkg::OP_KEY_GENERATION_COMMAND);

   // ----------------------------------------------------------------
   // Command decode and permission checks
   // ----------------------------------------------------------------
   always_comb
   begin
      ctrl_next.gen = is_gen;
      ctrl_next.use_scratch = 1'b0;
      ctrl_next.slot = slot;
      ctrl_next.dest = ecdh_keygen_pkg::DEST_OUT;
      enc_next = 1'b0;
      err_next = ecdh_keygen_pkg::STATUS_OK;
      if (is_ecdh)
      begin
         case (cmd.mode)
            ecdh_keygen_pkg::MODE_SLOT_CLEAR: enc_next = secret_protect_option;
            ecdh_keygen_pkg::MODE_SLOT_ENC: enc_next = 1'b1;
            ecdh_keygen_pkg::MODE_SLOT_SCRATCH: ctrl_next.dest = ecdh_keygen_pkg::DEST_SCRATCH;
            ecdh_keygen_pkg::MODE_SCR_CLEAR:
            begin
               ctrl_next.use_scratch = 1'b1;
               enc_next = secret_protect_option;
            end
            ecdh_keygen_pkg::MODE_SCR_ENC:
            begin
               ctrl_next.use_scratch = 1'b1;
               enc_next = 1'b1;
            end
            ecdh_keygen_pkg::MODE_SCR_SCRATCH:
            begin
               ctrl_next.use_scratch = 1'b1;
               ctrl_next.dest = ecdh_keygen_pkg::DEST_SCRATCH;
            end
            ecdh_keygen_pkg::MODE_SCR_TO_SLOT:
            begin
               ctrl_next.use_scratch = 1'b1;
               ctrl_next.dest = ecdh_keygen_pkg::DEST_SLOT;
            end
            default: err_next = ecdh_keygen_pkg::ERR_PARAM;
         endcase
         if (err_next == ecdh_keygen_pkg::STATUS_OK)
         begin
            if (!ctrl_next.use_scratch)
            begin
               if (!hi_zero || !ecdh_keygen_pkg::ECDH_SLOT_MASK[slot] || !slot_is_ecc_priv[slot] ||
                   !slot_ecdh_allowed[slot])
                  err_next = ecdh_keygen_pkg::ERR_POLICY;
            end
            else if (!scratch_key_valid_flag)
               err_next = ecdh_keygen_pkg::ERR_POLICY;
            else if (ctrl_next.dest == ecdh_keygen_pkg::DEST_SLOT)
            begin
               if (!hi_zero || slot_locked[slot])
                  err_next = ecdh_keygen_pkg::ERR_POLICY;
            end
            else if (cmd.key_id != ecdh_keygen_pkg::KEY_ID_ZERO)
               err_next = ecdh_keygen_pkg::ERR_PARAM;
         end
      end
      else if (is_gen)
      begin
         if (cmd.mode != ecdh_keygen_pkg::MODE_GEN_PRIVATE)
            err_next = ecdh_keygen_pkg::ERR_PARAM;
         else if (cmd.key_id == ecdh_keygen_pkg::KEY_ID_SCRATCH)
            ctrl_next.dest = ecdh_keygen_pkg::DEST_SCRATCH;
         else
         begin
            ctrl_next.dest = ecdh_keygen_pkg::DEST_SLOT;
            if (!hi_zero || !(slot_is_ecc_priv[slot] || slot_is_ecc_pub[slot]))
               err_next = ecdh_keygen_pkg::ERR_POLICY;
            else if (slot_locked[slot])
               err_next = ecdh_keygen_pkg::ERR_POLICY;
            else if (!ecdh_keygen_pkg::GEN_SLOT_MASK[slot] || !slot_is_ecc_priv[slot])
               err_next = ecdh_keygen_pkg::ERR_POLICY;
         end
      end
      else
         err_next = ecdh_keygen_pkg::ERR_PARAM;
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= ecdh_keygen_pkg::S_IDLE;
         cmd_ready <= 1'b0;
         data_ready <= 1'b0;
         busy <= 1'b0;
         ecc_start <= 1'b0;
         ecc_ctrl <= '0;
         enc_reg <= 1'b0;
         err_reg <= ecdh_keygen_pkg::STATUS_OK;
         reply_reg <= ecdh_keygen_pkg::STATUS_OK;
         cnt_reg <= 6'h00;
         out_last_reg <= 6'h00;
      end
      else
      begin
         ecc_start <= 1'b0;
         case (state_reg)
            ecdh_keygen_pkg::S_IDLE:
            begin
               cmd_ready <= 1'b1;
               busy <= 1'b0;
               if (take)
               begin
                  cmd_ready <= 1'b0;
                  busy <= 1'b1;
                  ecc_ctrl <= ctrl_next;
                  enc_reg <= enc_next;
                  err_reg <= err_next;
                  reply_reg <= err_next;
                  cnt_reg <= 6'h00;
                  // Gen answers with the public key; unencrypted output answers the secret only.
                  out_last_reg <= (is_gen || enc_next) ? ecdh_keygen_pkg::PUBKEY_LAST_IDX :
                                                          ecdh_keygen_pkg::SECRET_LAST_IDX;
                  if (is_ecdh)
                  begin
                     // The peer key is always drained, even when refused, to keep framing.
                     data_ready <= 1'b1;
                     state_reg <= ecdh_keygen_pkg::S_DATA;
                  end
                  else if (err_next != ecdh_keygen_pkg::STATUS_OK)
                     state_reg <= ecdh_keygen_pkg::S_REPLY;
                  else
                  begin
                     ecc_start <= 1'b1;
                     state_reg <= ecdh_keygen_pkg::S_WAIT;
                  end
               end
            end
            ecdh_keygen_pkg::S_DATA:
            begin
               if (data_valid && data_ready)
               begin
                  cnt_reg <= cnt_reg + 6'h01;
                  if (cnt_reg == ecdh_keygen_pkg::DATA_LAST_IDX)
                  begin
                     data_ready <= 1'b0;
                     cnt_reg <= 6'h00;
                     if (err_reg != ecdh_keygen_pkg::STATUS_OK)
                        state_reg <= ecdh_keygen_pkg::S_REPLY;
                     else
                     begin
                        ecc_start <= 1'b1;
                        state_reg <= ecdh_keygen_pkg::S_WAIT;
                     end
                  end
               end
            end
            ecdh_keygen_pkg::S_WAIT:
            begin
               if (ecc_done)
               begin
                  if (ecc_fail)
                  begin
                     reply_reg <= ecdh_keygen_pkg::ERR_FAULT;
                     state_reg <= ecdh_keygen_pkg::S_REPLY;
                  end
                  else if (ecc_ctrl.dest == ecdh_keygen_pkg::DEST_OUT || ecc_ctrl.gen)
                     state_reg <= ecdh_keygen_pkg::S_OUT;
                  else
                  begin
                     reply_reg <= ecdh_keygen_pkg::STATUS_OK;
                     state_reg <= ecdh_keygen_pkg::S_REPLY;
                  end
               end
            end
            ecdh_keygen_pkg::S_OUT:
            begin
               if (ecc_out_valid)
               begin
                  cnt_reg <= cnt_reg + 6'h01;
                  if (enc_reg && cnt_reg == ecdh_keygen_pkg::SECRET_LAST_IDX)
                  begin
                     cnt_reg <= 6'h00;
                     state_reg <= ecdh_keygen_pkg::S_NONCE;
                  end
                  else if (cnt_reg == out_last_reg)
                     state_reg <= ecdh_keygen_pkg::S_IDLE;
               end
            end
            ecdh_keygen_pkg::S_NONCE:
            begin
               cnt_reg <= cnt_reg + 6'h01;
               if (cnt_reg == ecdh_keygen_pkg::NONCE_LAST_IDX)
                  state_reg <= ecdh_keygen_pkg::S_IDLE;
            end
            ecdh_keygen_pkg::S_REPLY: state_reg <= ecdh_keygen_pkg::S_IDLE;
            default: state_reg <= ecdh_keygen_pkg::S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Peer key forwarding and answer bytes
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         ecc_in_valid <= 1'b0;
         ecc_in_byte <= 8'h00;
      end
      else
      begin
         // A refused command never hands its peer key to the curve engine.
         ecc_in_valid <= (state_reg == ecdh_keygen_pkg::S_DATA) && data_valid && data_ready &&
                         (err_reg == ecdh_keygen_pkg::STATUS_OK);
         ecc_in_byte <= data_byte;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         rsp_valid <= 1'b0;
         rsp_byte <= 8'h00;
         rsp_last <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         rsp_last <= 1'b0;
         case (state_reg)
            ecdh_keygen_pkg::S_OUT:
            begin
               rsp_valid <= ecc_out_valid;
               rsp_byte <= enc_reg ? (ecc_out_byte ^ mask_byte) : ecc_out_byte;
               rsp_last <= ecc_out_valid && !enc_reg && (cnt_reg == out_last_reg);
            end
            ecdh_keygen_pkg::S_NONCE:
            begin
               rsp_valid <= 1'b1;
               rsp_byte <= nonce_byte;
               rsp_last <= (cnt_reg == ecdh_keygen_pkg::NONCE_LAST_IDX);
            end
            ecdh_keygen_pkg::S_REPLY:
            begin
               rsp_valid <= 1'b1;
               rsp_byte <= reply_reg;
               rsp_last <= 1'b1;
            end
            default: rsp_byte <= rsp_byte;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Class flag and scratch key validity
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         asym_class <= 1'b0;
      else if (take)
         asym_class <= is_ecdh || is_gen || cmd.opcode == ecdh_keygen_pkg::OP_SIGN ||
                       cmd.opcode == ecdh_keygen_pkg::OP_VERIFY ||
                       cmd.opcode == ecdh_keygen_pkg::OP_BOOT_CHECK;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         scratch_key_valid_flag <= 1'b0;
      else if (state_reg == ecdh_keygen_pkg::S_WAIT && ecc_done && !ecc_fail &&
               ecc_ctrl.dest == ecdh_keygen_pkg::DEST_SCRATCH)
         scratch_key_valid_flag <= 1'b1;
      else if (ecc_start && (ecc_ctrl.use_scratch || ecc_ctrl.dest == ecdh_keygen_pkg::DEST_SCRATCH))
         scratch_key_valid_flag <= 1'b0;
   end

   secret_cipher u_cipher
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .hold(state_reg == ecdh_keygen_pkg::S_OUT || state_reg == ecdh_keygen_pkg::S_NONCE),
      .entropy_byte(entropy_byte),
      .io_protect_key(io_protect_key),
      .idx(cnt_reg[4:0]),
      .mask_byte(mask_byte),
      .nonce_byte(nonce_byte)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_class_flag_set: assert property (take && cmd.opcode == ecdh_keygen_pkg::OP_SIGN |=> asym_class)
      else $error("Class flag missing for signing opcode.");
   a_peer_key_taken: assert property (take && is_ecdh |=> data_ready && !ecc_start)
      else $error("Shared-secret command did not open data intake.");
   a_slot_range: assert property (ecc_start && !ecc_ctrl.gen && !ecc_ctrl.use_scratch |->
                                  ecdh_keygen_pkg::ECDH_SLOT_MASK[ecc_ctrl.slot])
      else $error("Shared secret started on a forbidden slot.");
   a_gen_slot_range: assert property (ecc_start && ecc_ctrl.gen && ecc_ctrl.dest == ecdh_keygen_pkg::DEST_SLOT |->
                                      ecdh_keygen_pkg::GEN_SLOT_MASK[ecc_ctrl.slot])
      else $error("Key generation started on a forbidden slot.");
   a_scratch_consumed: assert property (ecc_start && ecc_ctrl.use_scratch |=> !scratch_key_valid_flag)
      else $error("Scratch key still valid after use.");
   a_bad_mode_error: assert property (take && is_gen && cmd.mode != ecdh_keygen_pkg::MODE_GEN_PRIVATE |=>
                                      !ecc_start ##1 rsp_valid && rsp_last && rsp_byte == ecdh_keygen_pkg::ERR_PARAM)
      else $error("Unlisted mode not answered with an error byte.");
   a_locked_refused: assert property (take && is_gen && cmd.mode == ecdh_keygen_pkg::MODE_GEN_PRIVATE &&
                                      cmd.key_id != ecdh_keygen_pkg::KEY_ID_SCRATCH && slot_locked[slot] |=>
                                      !ecc_start ##1 rsp_valid && rsp_byte != ecdh_keygen_pkg::STATUS_OK)
      else $error("Locked slot was not refused.");
   a_fault_byte: assert property (state_reg == ecdh_keygen_pkg::S_WAIT && ecc_done && ecc_fail |=>
                                  ##1 rsp_valid && rsp_last && rsp_byte == ecdh_keygen_pkg::ERR_FAULT)
      else $error("Engine fault not answered with one error byte.");
   a_store_status: assert property (state_reg == ecdh_keygen_pkg::S_WAIT && ecc_done && !ecc_fail &&
                                    !ecc_ctrl.gen && ecc_ctrl.dest != ecdh_keygen_pkg::DEST_OUT |=>
                                    ##1 rsp_valid && rsp_last && rsp_byte == ecdh_keygen_pkg::STATUS_OK)
      else $error("Store mode did not answer a zero status byte.");

endmodule

// [ecdh_keygen_pkg.sv]
// Constants, types and encodings shared by the asymmetric-key command engine.
// Function
// - Opcode 0x43 is shared secret, 0x40 keygen.
// - Opcodes 0x41, 0x45, 0x80 share this class.
// - Slot key must be private and permit command.
// - Stored-key shared secret only slots 0, 2-4.
// - Slot source: 0x0C clear, 0x0E encrypted, 0x08 scratch.
// - Scratch source: 0x0D clear, 0x0F encrypted, 0x09 scratch.
// - Mode 0x05 scratch key, result into slot.
// - Host sends 32-byte X then 32-byte Y.
// - Clear modes return 32-byte secret unencrypted.
// - Encrypted modes return secret then 32-byte nonce.
// - Failing output-buffer command returns one error byte.
// - Store modes return one status byte, 0x00 ok.
// - Encrypt with protection key, output buffer only.
// - Protect option 1 also encrypts clear modes.
// - Using scratch key clears valid; store resets it.
// - Keygen errors unless slot is curve key.
// - Private keygen into slot also derives public key.
// - Keygen into locked slot fails.
// - Invalid generated private key reports an error.
// - Private keygen only slots 2-4, no authorization.
// - Keygen 0x04 stores key, returns 64-byte public key.
package ecdh_keygen_pkg;

   // ----------------------------------------------------------------
   // Opcodes and modes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_ECDH = 8'h43;
   localparam logic [7:0] OP_KEY_GENERATION_COMMAND = 8'h40;
   localparam logic [7:0] OP_SIGN = 8'h41;
   localparam logic [7:0] OP_VERIFY = 8'h45;
   localparam logic [7:0] OP_BOOT_CHECK = 8'h80;

   localparam logic [7:0] MODE_SLOT_CLEAR = 8'h0C;
   localparam logic [7:0] MODE_SLOT_ENC = 8'h0E;
   localparam logic [7:0] MODE_SLOT_SCRATCH = 8'h08;
   localparam logic [7:0] MODE_SCR_CLEAR = 8'h0D;
   localparam logic [7:0] MODE_SCR_ENC = 8'h0F;
   localparam logic [7:0] MODE_SCR_SCRATCH = 8'h09;
   localparam logic [7:0] MODE_SCR_TO_SLOT = 8'h05;
   localparam logic [7:0] MODE_GEN_PRIVATE = 8'h04;

   localparam logic [15:0] KEY_ID_SCRATCH = 16'hFFFF;
   localparam logic [15:0] KEY_ID_ZERO = 16'h0000;

   // ----------------------------------------------------------------
   // Slot permissions of this variant
   // ----------------------------------------------------------------
   localparam logic [15:0] ECDH_SLOT_MASK = 16'h001D;
   localparam logic [15:0] GEN_SLOT_MASK = 16'h001C;

   // ----------------------------------------------------------------
   // Lengths and answer codes
   // ----------------------------------------------------------------
   localparam logic [5:0] DATA_LAST_IDX = 6'h3F;
   localparam logic [5:0] SECRET_LAST_IDX = 6'h1F;
   localparam logic [5:0] PUBKEY_LAST_IDX = 6'h3F;
   localparam logic [5:0] NONCE_LAST_IDX = 6'h1F;

   localparam logic [7:0] STATUS_OK = 8'h00;
   localparam logic [7:0] ERR_PARAM = 8'h03;
   localparam logic [7:0] ERR_POLICY = 8'h0F;
   localparam logic [7:0] ERR_FAULT = 8'h05;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      DEST_OUT = 2'h0,
      DEST_SCRATCH = 2'h1,
      DEST_SLOT = 2'h2
   } dest_t;

   typedef enum logic [5:0]
   {
      S_IDLE = 6'h01,
      S_DATA = 6'h02,
      S_WAIT = 6'h04,
      S_OUT = 6'h08,
      S_NONCE = 6'h10,
      S_REPLY = 6'h20
   } state_t;

   typedef struct packed
   {
      logic [7:0] opcode;
      logic [7:0] mode;
      logic [15:0] key_id;
   } cmd_t;

   typedef struct packed
   {
      logic gen;
      logic use_scratch;
      logic [3:0] slot;
      dest_t dest;
   } ecc_ctrl_t;

endpackage

// [secret_cipher.sv]
// Output nonce source and per-byte encryption mask for the shared secret.
`timescale 1ns/1ps
module secret_cipher
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hold,
   input wire logic [7:0] entropy_byte,
   input wire logic [255:0] io_protect_key,
   input wire logic [4:0] idx,
   output logic [7:0] mask_byte,
   output logic [7:0] nonce_byte
);

   logic [255:0] nonce_reg;
   logic [7:0] mask_arr [0:31];
   logic [7:0] nonce_arr [0:31];

   // The nonce keeps stirring in entropy and freezes while a reply uses it,
   // so the mask and the nonce that follows always belong together.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         nonce_reg <= 256'h0;
      else if (!hold)
         nonce_reg <= {nonce_reg[247:0], nonce_reg[255:248] ^ entropy_byte};
   end

   genvar i;
   generate
      for (i = 0; i < 32; i = i + 1)
      begin : g_byte
         assign nonce_arr[i] = nonce_reg[8*i +: 8];
         assign mask_arr[i] = nonce_reg[8*i +: 8] ^ io_protect_key[8*i +: 8];
      end
   endgenerate

   assign mask_byte = mask_arr[idx];
   assign nonce_byte = nonce_arr[idx];

endmodule

// [ecc_engine_model.sv]
// Behavioural curve engine that answers each start of the command engine.
`timescale 1ns/1ps
module ecc_engine_model
(
   input wire logic ref_clk,
   input wire logic ecc_start,
   input wire ecdh_keygen_pkg::ecc_ctrl_t ecc_ctrl,
   input wire logic fail_req,
   output logic ecc_done,
   output logic ecc_fail,
   output logic ecc_out_valid,
   output logic [7:0] ecc_out_byte
);
   // Key generation answers slowly and shared secrets quickly, so both paces are exercised.
   initial
   begin
      ecc_done = 1'b0;
      ecc_fail = 1'b0;
      ecc_out_valid = 1'b0;
      ecc_out_byte = 8'h00;
      forever
      begin
         @(posedge ref_clk);
         if (ecc_start === 1'b1)
         begin
            repeat (ecc_ctrl.gen ? 9 : 2) @(posedge ref_clk);
            ecc_done <= 1'b1;
            ecc_fail <= fail_req;
            @(posedge ref_clk);
            ecc_done <= 1'b0;
            ecc_fail <= 1'b0;
            if (!fail_req && (ecc_ctrl.gen || ecc_ctrl.dest == ecdh_keygen_pkg::DEST_OUT))
            begin
               // A generated key also yields its 64-byte public key.
               for (int k = 0; k < (ecc_ctrl.gen ? 64 : 32); k++)
               begin
                  ecc_out_valid <= 1'b1;
                  ecc_out_byte <= 8'hA0 + 8'(k);
                  @(posedge ref_clk);
               end
            end
            // Released bytes never repeat the last value.
            ecc_out_valid <= 1'b0;
            ecc_out_byte <= 8'h5A;
         end
      end
   end
endmodule

// [ecdh_keygen_command_engine_tb_top.sv]
// Self-checking bench for the shared-secret and key generation command engine.
`timescale 1ns/1ps
module ecdh_keygen_command_engine_tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   ecdh_keygen_pkg::cmd_t cmd = '0;
   logic data_valid = 1'b0;
   logic [7:0] data_byte = 8'h00;
   logic [15:0] slot_is_ecc_priv = 16'h003F;
   logic [15:0] slot_ecdh_allowed = 16'h001F;
   logic [15:0] slot_locked = 16'h0000;
   logic secret_protect_option = 1'b0;
   logic fail_req = 1'b0;
   logic [255:0] key = {8{32'h1E2D_3C4B}};
   logic cmd_ready, data_ready, ecc_start, ecc_in_valid, ecc_done, ecc_fail, ecc_out_valid;
   logic rsp_valid, rsp_last, asym_class, scratch_key_valid_flag, busy;
   logic [7:0] ecc_in_byte, ecc_out_byte, rsp_byte;
   ecdh_keygen_pkg::ecc_ctrl_t ecc_ctrl;
   logic [7:0] q[$];
   int error_cnt = 0;
   int checked = 0;
   int fwd = 0;

   always #2.5 ref_clk = ~ref_clk;

   ecdh_keygen_command_engine i_dut
   (
      .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
      .data_valid(data_valid), .data_byte(data_byte), .data_ready(data_ready),
      .slot_is_ecc_priv(slot_is_ecc_priv), .slot_is_ecc_pub(16'h0000), .slot_ecdh_allowed(slot_ecdh_allowed),
      .slot_locked(slot_locked), .secret_protect_option(secret_protect_option), .io_protect_key(key),
      .entropy_byte(8'h96), .ecc_start(ecc_start), .ecc_ctrl(ecc_ctrl), .ecc_in_valid(ecc_in_valid),
      .ecc_in_byte(ecc_in_byte), .ecc_done(ecc_done), .ecc_fail(ecc_fail), .ecc_out_valid(ecc_out_valid),
      .ecc_out_byte(ecc_out_byte), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rsp_last(rsp_last),
      .asym_class(asym_class), .scratch_key_valid_flag(scratch_key_valid_flag), .busy(busy)
   );

   ecc_engine_model i_engine
   (
      .ref_clk(ref_clk), .ecc_start(ecc_start), .ecc_ctrl(ecc_ctrl), .fail_req(fail_req),
      .ecc_done(ecc_done), .ecc_fail(ecc_fail), .ecc_out_valid(ecc_out_valid), .ecc_out_byte(ecc_out_byte)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Peer bytes must reach the curve engine in the order in which they were sent.
   always @(posedge ref_clk)
      if (ecc_in_valid === 1'b1)
      begin
         check(ecc_in_byte, 8'(fwd));
         fwd++;
      end

   // Issues one command, sends 64 peer bytes for a shared secret, collects the answer.
   task automatic run(input logic [7:0] op, input logic [7:0] md, input logic [15:0] id, input int len);
      int n;
      q = {};
      fwd = 0;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 50)
      begin
         @(posedge ref_clk);
         n++;
      end
      check({7'h00, busy}, 8'h00);
      cmd_valid <= 1'b1;
      cmd <= '{op, md, id};
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      @(posedge ref_clk);
      check({7'h00, busy}, 8'h01);
      if (op == ecdh_keygen_pkg::OP_ECDH)
      begin
         while (data_ready !== 1'b1 && n < 100)
         begin
            @(posedge ref_clk);
            n++;
         end
         for (int k = 0; k < 64; k++)
         begin
            data_valid <= 1'b1;
            data_byte <= 8'(k);
            @(posedge ref_clk);
         end
         data_valid <= 1'b0;
      end
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
         if (rsp_valid === 1'b1)
            q.push_back(rsp_byte);
      end
      while (!(rsp_valid === 1'b1 && rsp_last === 1'b1) && n < 300);
      check(8'(q.size()), 8'(len));
   endtask

   task automatic t_class;
      logic [7:0] ops[3] = '{8'h41, 8'h45, 8'h80};
      foreach (ops[i])
      begin
         run(ops[i], 8'h00, 16'h0000, 1);
         check({7'h00, asym_class}, 8'h01);
         check(q[0], ecdh_keygen_pkg::ERR_PARAM);
      end
      run(8'h12, 8'h00, 16'h0000, 1);
      check({7'h00, asym_class}, 8'h00);
   endtask

   task automatic t_key_generation_command;
      run(8'h40, 8'h04, 16'h0002, 64);
      check({7'h00, asym_class}, 8'h01);
      foreach (q[k])
         check(q[k], 8'hA0 + 8'(k));
      slot_locked <= 16'h0008;
      run(8'h40, 8'h04, 16'h0003, 1);
      check(q[0], ecdh_keygen_pkg::ERR_POLICY);
      slot_locked <= 16'h0000;
      run(8'h40, 8'h04, 16'h0005, 1);
      check(q[0], ecdh_keygen_pkg::ERR_POLICY);
      run(8'h40, 8'h05, 16'h0002, 1);
      check(q[0], ecdh_keygen_pkg::ERR_PARAM);
      run(8'h40, 8'h04, 16'h0006, 1);
      check(q[0], ecdh_keygen_pkg::ERR_POLICY);
      fail_req <= 1'b1;
      run(8'h40, 8'h04, 16'h0004, 1);
      check(q[0], ecdh_keygen_pkg::ERR_FAULT);
      fail_req <= 1'b0;
   endtask

   task automatic t_scratch;
      run(8'h40, 8'h04, 16'hFFFF, 64);
      check({7'h00, scratch_key_valid_flag}, 8'h01);
      run(8'h43, 8'h0D, 16'h0000, 32);
      foreach (q[k])
         check(q[k], 8'hA0 + 8'(k));
      check({7'h00, scratch_key_valid_flag}, 8'h00);
      run(8'h43, 8'h0D, 16'h0000, 1);
      check(q[0], ecdh_keygen_pkg::ERR_POLICY);
      run(8'h43, 8'h08, 16'h0000, 1);
      check(q[0], ecdh_keygen_pkg::STATUS_OK);
      check({7'h00, scratch_key_valid_flag}, 8'h01);
      run(8'h43, 8'h07, 16'h0000, 1);
      check(q[0], ecdh_keygen_pkg::ERR_PARAM);
      check({7'h00, scratch_key_valid_flag}, 8'h01);
      run(8'h43, 8'h09, 16'h0000, 1);
      check(q[0], ecdh_keygen_pkg::STATUS_OK);
      check({7'h00, scratch_key_valid_flag}, 8'h01);
      run(8'h43, 8'h05, 16'h0007, 1);
      check(q[0], ecdh_keygen_pkg::STATUS_OK);
      check({7'h00, scratch_key_valid_flag}, 8'h00);
   endtask

   task automatic t_slot_out;
      run(8'h43, 8'h0E, 16'h0000, 64);
      for (int k = 0; k < 32; k++)
         check(q[k] ^ q[32 + k], (8'hA0 + 8'(k)) ^ key[8 * k +: 8]);
      check(8'(fwd), 8'h40);
      run(8'h43, 8'h0C, 16'h0001, 1);
      check(q[0], ecdh_keygen_pkg::ERR_POLICY);
      check(8'(fwd), 8'h00);
      run(8'h43, 8'h0C, 16'h0003, 32);
      check(q[31], 8'hBF);
      secret_protect_option <= 1'b1;
      run(8'h43, 8'h0C, 16'h0000, 64);
      for (int k = 0; k < 32; k++)
         check(q[k] ^ q[32 + k], (8'hA0 + 8'(k)) ^ key[8 * k +: 8]);
      secret_protect_option <= 1'b0;
   endtask

   task automatic test_done;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      // About twenty commands of under 200 cycles each fit well inside this span.
      #100000;
      error_cnt++;
      test_done();
   end

   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      t_class();
      t_key_generation_command();
      t_scratch();
      t_slot_out();
      test_done();
   end
endmodule
